/* File: bench/mco_clock_output_tb.sv */
// testbench for the microcontroller clock output unit
// assumes the package constants and a 125 MHz clock; low-freq pins are
// made here with two unrelated periods so the chosen source can be told apart
`default_nettype none

module mco_clock_output_tb
  import mco_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int RC_HALF = 15259;
  localparam int EXT_HALF = 20000;
  localparam int RC_CYC = 2 * RC_HALF / 8;
  localparam int EXT_CYC = 2 * EXT_HALF / 8;

  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic soft_reset = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic sleep_cmd = 1'b0;
  logic irq_pending = 1'b0;
  logic ext_low_freq_crystal_select = 1'b0;
  logic rc_lf_clk = 1'b0;
  logic ext_lf_clk = 1'b0;
  logic third_general_pin;
  logic xtal_osc_en;
  logic clr = 1'b0;
  logic [31:0] rise_cnt;
  logic [31:0] period;
  int n_errors = 0;
  int checks_done = 0;
  logic [7:0] rdv;
  logic [31:0] c;
  logic [31:0] p;
  longint unsigned freqs [7] = '{FREQ_30M_HZ, FREQ_15M_HZ, FREQ_10M_HZ,
    FREQ_4M_HZ, FREQ_3M_HZ, FREQ_2M_HZ, FREQ_1M_HZ};
  logic [31:0] tails [4] = '{32'(TAIL_NONE), 32'(TAIL_128), 32'(TAIL_256), 32'(TAIL_512)};

  // clocks: system, and two free running low-freq sources
  always #4 clk = ~clk;
  always #RC_HALF rc_lf_clk = ~rc_lf_clk;
  always #EXT_HALF ext_lf_clk = ~ext_lf_clk;

  mco_clock_output u_mco_clock_output (
    .clk(clk), .resetn(resetn), .soft_reset(soft_reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sleep_cmd(sleep_cmd), .irq_pending(irq_pending),
    .ext_low_freq_crystal_select(ext_low_freq_crystal_select),
    .rc_lf_clk(rc_lf_clk), .ext_lf_clk(ext_lf_clk),
    .third_general_pin(third_general_pin), .xtal_osc_en(xtal_osc_en)
  );

  mco_mcu_model u_mco_mcu_model (
    .clk(clk), .resetn(resetn), .clr(clr), .pin(third_general_pin),
    .rise_cnt(rise_cnt), .period(period)
  );

  // -------------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------------
  // tolerance compare; an unknown never counts as inside the band
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got,
    input int tol);
    logic ok;
    ok = (got + tol >= exp) && (got <= exp + tol);
    checks_done++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("wrong value %s exp %0d got %0d", nm, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic restart_meter();
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    cyc(1);
  endtask

  task automatic edges(input int w, output logic [31:0] n);
    restart_meter();
    cyc(w);
    n = rise_cnt;
  endtask

  // bounded wait for three fresh edges, then take the last spacing
  task automatic period_of(output logic [31:0] r);
    int i;
    restart_meter();
    r = 32'h0000_0000;
    for (i = 0; i < 25000 && rise_cnt < 3; i++)
      @(posedge clk);
    if (rise_cnt >= 3)
      r = period;
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // -------------------------------------------------------------------
  // test sequence
  // -------------------------------------------------------------------
  initial
  begin
    cyc(20);
    resetn <= 1'b1;
    rd(CTRL_OFFSET, rdv);
    chk("ctrl reset", 32'(CTRL_RESET), 32'(rdv), 0);
    period_of(p);
    chk("reset period", 125, p, 2);
    // every divided code, counted over a fixed window
    for (int k = 0; k < 7; k++)
    begin
      wr(CTRL_OFFSET, 8'(k));
      cyc(300);
      edges(1250, c);
      chk("edges", 32'(freqs[k] * 1250 / CLK_HZ), c, 2);
    end
    // the divider keeps toggling until the slow clock is low, so let it switch
    wr(CTRL_OFFSET, 8'h07);
    cyc(2600);
    period_of(p);
    chk("lf period", RC_CYC, p, 2);
    wr(8'h0B, 8'hFF);
    rd(8'h0B, rdv);
    chk("unmapped", 32'h0000_0000, 32'(rdv), 0);
    wr(CTRL_OFFSET, 8'hFF);
    rd(CTRL_OFFSET, rdv);
    chk("readback", 32'h0000_003F, 32'(rdv), 0);
    // sleep with low-freq enable, then the external source
    wr(CTRL_OFFSET, 8'h08);
    @(posedge clk);
    sleep_cmd <= 1'b1;
    cyc(50);
    chk("xtal sleep", 0, 32'(xtal_osc_en), 0);
    period_of(p);
    chk("sleep lf", RC_CYC, p, 2);
    @(posedge clk);
    ext_low_freq_crystal_select <= 1'b1;
    period_of(p);
    chk("ext lf", EXT_CYC, p, 2);
    @(posedge clk);
    ext_low_freq_crystal_select <= 1'b0;
    sleep_cmd <= 1'b0;
    cyc(50);
    chk("xtal wake", 1, 32'(xtal_osc_en), 0);
    cyc(2600);
    edges(1250, c);
    chk("wake edges", 300, c, 2);
    // every tail length at 30 MHz, then the pin must stay low
    for (int t = 0; t < 4; t++)
    begin
      wr(CTRL_OFFSET, 8'(t << 4));
      cyc(300);
      @(posedge clk);
      sleep_cmd <= 1'b1;
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      cyc(2500);
      chk("tail edges", tails[t], rise_cnt, 1);
      edges(200, c);
      chk("stopped", 0, c, 0);
      chk("pin low", 0, 32'(third_general_pin), 0);
      @(posedge clk);
      sleep_cmd <= 1'b0;
      cyc(50);
      chk("xtal on", 1, 32'(xtal_osc_en), 0);
    end
    // pending interrupt holds the clock until the mcu reads it
    wr(CTRL_OFFSET, 8'h00);
    @(posedge clk);
    irq_pending <= 1'b1;
    sleep_cmd <= 1'b1;
    cyc(100);
    edges(1250, c);
    chk("irq run", 300, c, 2);
    chk("irq xtal", 1, 32'(xtal_osc_en), 0);
    @(posedge clk);
    irq_pending <= 1'b0;
    cyc(50);
    chk("irq read", 0, 32'(xtal_osc_en), 0);
    edges(100, c);
    chk("irq stop", 0, c, 0);
    // software reset, then a hardware reset in mid-run
    wr(CTRL_OFFSET, 8'h35);
    @(posedge clk);
    sleep_cmd <= 1'b0;
    soft_reset <= 1'b1;
    @(posedge clk);
    soft_reset <= 1'b0;
    rd(CTRL_OFFSET, rdv);
    chk("soft reset", 32'(CTRL_RESET), 32'(rdv), 0);
    period_of(p);
    chk("soft period", 125, p, 2);
    wr(CTRL_OFFSET, 8'h35);
    @(posedge clk);
    resetn <= 1'b0;
    cyc(2);
    resetn <= 1'b1;
    rd(CTRL_OFFSET, rdv);
    chk("hard reset", 32'(CTRL_RESET), 32'(rdv), 0);
    period_of(p);
    chk("hard period", 125, p, 2);
    end_of_test();
  end

  // hang guard, about 96k cycles against some 64k expected
  initial
  begin
    #768_000;
    n_errors++;
    end_of_test();
  end

endmodule

`default_nettype wire

/* File: bench/mco_mcu_model.sv */
// microcontroller side model: counts rising edges of the supplied clock
// and measures the spacing of the last two, in system clock cycles
// assumes the pin is sampled on the same 125 MHz clock as the design
`default_nettype none

module mco_mcu_model (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // measurement control and observed clock pin
  input wire logic clr,
  input wire logic pin,
  // rising edge count and last period
  output logic [31:0] rise_cnt,
  output logic [31:0] period
);
  timeunit 1ns;
  timeprecision 1ps;

  logic pin_q;
  logic [31:0] since;
  logic rise;

  // the mcu only acts on rising edges; a stopped pin adds nothing
  assign rise = pin && !pin_q;

  // edge detect and period meter
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_q <= 1'b0;
      since <= 32'h0000_0000;
      period <= 32'h0000_0000;
    end
    else
    begin
      pin_q <= pin;
      since <= rise ? 32'h0000_0001 : since + 32'h0000_0001;
      if (rise)
        period <= since;
    end
  end

  // edge counter, cleared by the bench before each window
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rise_cnt <= 32'h0000_0000;
    else if (clr)
      rise_cnt <= 32'h0000_0000;
    else if (rise)
      rise_cnt <= rise_cnt + 32'h0000_0001;
  end

endmodule

`default_nettype wire

/* File: rtl/mco_clock_output.sv */
// microcontroller clock output: divider, low-frequency switch, sleep tail
// assumes sleep and interrupt state come from same-clock logic and the
// low-frequency clocks arrive asynchronously on pins
`default_nettype none

module mco_clock_output
  import mco_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic soft_reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // device state
  input wire logic sleep_cmd,
  input wire logic irq_pending,
  input wire logic ext_low_freq_crystal_select,
  // low-frequency clock pins
  input wire logic rc_lf_clk,
  input wire logic ext_lf_clk,
  // outputs
  output logic third_general_pin,
  output logic xtal_osc_en
);

  mco_ctrl_s ctrl_reg;
  logic [7:0] rdata_reg;
  logic rc_s1_reg, rc_s2_reg, ext_s1_reg, ext_s2_reg;
  logic lf_level;
  logic eff_sleep;
  mco_state_e state_reg, state_next;
  logic [9:0] tail_cnt_reg;
  mco_src_e src_reg, want_src;
  logic [31:0] inc_reg, want_inc;
  logic change_req, do_switch;
  logic pin_reg, pin_d_reg, pin_rise;
  logic nco_wave;

  // -------------------------------------------------------------------
  // control register
  // -------------------------------------------------------------------
  // software reset returns the register to its default just like power-on
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ctrl_reg <= CTRL_RESET; // [RQ11]
    else if (soft_reset)
      ctrl_reg <= CTRL_RESET; // [RQ11]
    else if (reg_wr && reg_addr == CTRL_OFFSET)
      ctrl_reg <= {2'b00, reg_wdata[5:0]};
  end

  // read data for exactly the cycle after the strobe; other addresses read 0
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rdata_reg <= 8'h00;
    else if (reg_rd && reg_addr == CTRL_OFFSET)
      rdata_reg <= ctrl_reg;
    else
      rdata_reg <= 8'h00;
  end

  assign reg_rdata = rdata_reg;

  // -------------------------------------------------------------------
  // low-frequency source
  // -------------------------------------------------------------------
  // both pins are asynchronous, so each passes two flops before use
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rc_s1_reg <= 1'b0;
      rc_s2_reg <= 1'b0;
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
    end
    else
    begin
      rc_s1_reg <= rc_lf_clk;
      rc_s2_reg <= rc_s1_reg;
      ext_s1_reg <= ext_lf_clk;
      ext_s2_reg <= ext_s1_reg;
    end
  end

  // external crystal replaces the rc oscillator once selected
  assign lf_level = ext_low_freq_crystal_select ? ext_s2_reg : rc_s2_reg; // [RQ4] [RQ12]

  // -------------------------------------------------------------------
  // sleep sequencing
  // -------------------------------------------------------------------
  // a pending interrupt holds the device awake until it has been read
  assign eff_sleep = sleep_cmd && !irq_pending; // [RQ10]

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RUN:
        if (eff_sleep)
        begin
          if (ctrl_reg.lfc_en)
            state_next = ST_LF; // [RQ6] [RQ7]
          else if (ctrl_reg.tail_sel == 2'h0)
            state_next = ST_STOP; // [RQ8]
          else
            state_next = ST_TAIL; // [RQ9]
        end
      ST_TAIL:
        if (!eff_sleep)
          state_next = ST_RUN;
        else if (pin_rise && tail_cnt_reg == 10'h001)
          state_next = ST_STOP; // [RQ9]
      ST_STOP:
        if (!eff_sleep)
          state_next = ST_RUN;
        else if (ctrl_reg.lfc_en)
          state_next = ST_LF;
      ST_LF:
        if (!eff_sleep)
          state_next = ST_RUN;
        else if (!ctrl_reg.lfc_en)
          state_next = ST_STOP;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      state_reg <= ST_RUN;
    else if (soft_reset)
      state_reg <= ST_RUN;
    else
      state_reg <= state_next;
  end

  // tail counter counts rising edges of the pin after sleep entry
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      tail_cnt_reg <= TAIL_NONE;
    else if (state_reg == ST_RUN)
      tail_cnt_reg <= mco_tail_cycles(ctrl_reg.tail_sel); // [RQ9]
    else if (state_reg == ST_TAIL && pin_rise)
      tail_cnt_reg <= tail_cnt_reg - 10'h001;
  end

  // crystal runs only while awake or finishing the tail
  assign xtal_osc_en = (state_reg == ST_RUN) || (state_reg == ST_TAIL); // [RQ5]

  // -------------------------------------------------------------------
  // source selection
  // -------------------------------------------------------------------
  always_comb
  begin
    want_inc = mco_freq_inc(ctrl_reg.freq_sel); // [RQ2]
    want_src = SRC_OFF;
    unique case (state_reg)
      ST_RUN, ST_TAIL:
        want_src = (ctrl_reg.freq_sel == FREQ_SEL_LF) ? SRC_LF : SRC_NCO; // [RQ7]
      ST_STOP:
        want_src = SRC_OFF; // [RQ8]
      ST_LF:
        want_src = SRC_LF; // [RQ6]
    endcase
  end

  // switching only while the pin is low, and into a low source, means no
  // pulse is ever cut short; the cost is up to one old period of latency, or up to half a low-frequency period when switching into SRC_LF
  assign change_req = (want_src != src_reg) ||
                      (want_src == SRC_NCO && inc_reg != want_inc);
  assign do_switch = change_req && !pin_reg &&
                     (want_src != SRC_LF || !lf_level); // [RQ13]

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      src_reg <= SRC_NCO;
      inc_reg <= INC_RESET; // [RQ3]
    end
    else if (soft_reset)
    begin
      src_reg <= SRC_NCO;
      inc_reg <= INC_RESET;
    end
    else if (do_switch)
    begin
      src_reg <= want_src;
      inc_reg <= want_inc;
    end
  end

  // divider on the system clock standing in for the crystal; it keeps running
  // until the source has moved off it, or a high half would freeze on the pin
  // and the switch, which waits for a low pin, would never come
  mco_nco u_nco (
    .clk(clk),
    .resetn(resetn),
    .restart(do_switch || soft_reset),
    .run(src_reg == SRC_NCO),
    .inc(inc_reg),
    .wave(nco_wave)
  ); // [RQ1]

  // -------------------------------------------------------------------
  // output pin
  // -------------------------------------------------------------------
  // the switch cycle forces low so a stale divider phase cannot leak out
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pin_reg <= 1'b0;
    else if (do_switch || soft_reset)
      pin_reg <= 1'b0; // [RQ13]
    else
    begin
      unique case (src_reg)
        SRC_NCO: pin_reg <= nco_wave; // [RQ1]
        SRC_LF: pin_reg <= lf_level; // [RQ6]
        default: pin_reg <= 1'b0; // [RQ8]
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pin_d_reg <= 1'b0;
    else
      pin_d_reg <= pin_reg;
  end

  assign pin_rise = pin_reg && !pin_d_reg;
  assign third_general_pin = pin_reg;

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  soft_reset_ctrl_a: assert property (soft_reset |=> ctrl_reg == CTRL_RESET) // [RQ11]
    else $error("control register not restored by software reset");

  read_data_a: assert property (
    reg_rd && reg_addr == CTRL_OFFSET |=> reg_rdata == {2'b00, $past(ctrl_reg[5:0])})
    else $error("control register read data wrong");

  read_idle_a: assert property (
    !(reg_rd && reg_addr == CTRL_OFFSET) |=> reg_rdata == 8'h00)
    else $error("read data not zero outside the read cycle");

  irq_hold_a: assert property ( // [RQ10]
    irq_pending && state_reg == ST_RUN && !soft_reset |=> state_reg == ST_RUN)
    else $error("clock left running state with interrupt pending");

  wake_run_a: assert property ( // [RQ7]
    state_reg != ST_RUN && !eff_sleep |=> state_reg == ST_RUN && xtal_osc_en)
    else $error("clock not resumed on wake");

  stop_entry_a: assert property ( // [RQ8]
    state_reg == ST_RUN && eff_sleep && !ctrl_reg.lfc_en && ctrl_reg.tail_sel == 2'h0
    && !soft_reset |=> state_reg == ST_STOP)
    else $error("clock not stopped on sleep entry without tail");

  tail_load_a: assert property ( // [RQ9]
    state_reg == ST_RUN && eff_sleep && !ctrl_reg.lfc_en && ctrl_reg.tail_sel != 2'h0
    && !soft_reset |=> state_reg == ST_TAIL
    && tail_cnt_reg == mco_tail_cycles($past(ctrl_reg.tail_sel)))
    else $error("tail not loaded on sleep entry");

  tail_done_a: assert property ( // [RQ9]
    state_reg == ST_TAIL && eff_sleep && pin_rise && tail_cnt_reg == 10'h001
    && !soft_reset |=> state_reg == ST_STOP && !xtal_osc_en)
    else $error("clock not stopped after the last tail cycle");

  lf_entry_a: assert property ( // [RQ6]
    state_reg == ST_RUN && eff_sleep && ctrl_reg.lfc_en && !soft_reset
    |=> state_reg == ST_LF ##0 !xtal_osc_en)
    else $error("low-frequency clock not chosen in sleep");

  stopped_low_a: assert property ( // [RQ8]
    src_reg == SRC_OFF && !do_switch |=> !third_general_pin)
    else $error("pin toggled while clock stopped");

  switch_low_a: assert property ( // [RQ13]
    src_reg != $past(src_reg) |-> !$past(third_general_pin, 1))
    else $error("source switched while pin high");

  lf_follow_a: assert property ( // [RQ6]
    src_reg == SRC_LF && !do_switch && !soft_reset |=> third_general_pin == $past(lf_level))
    else $error("pin does not follow low-frequency clock");

  soft_default_a: assert property ( // [RQ11]
    soft_reset |=> src_reg == SRC_NCO && inc_reg == INC_RESET && !third_general_pin)
    else $error("output not back to its default after software reset");

  xtal_sleep_a: assert property ($fell(xtal_osc_en) |-> $past(eff_sleep)) // [RQ5]
    else $error("crystal disabled while awake");

endmodule

`default_nettype wire

/* File: rtl/mco_nco.sv */
// numerically controlled square wave from the system clock
// assumes restart is a one-cycle pulse and the step is held while running
`default_nettype none

module mco_nco
  import mco_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // control
  input wire logic restart,
  input wire logic run,
  input wire logic [31:0] inc,
  // square wave, top bit of the phase accumulator
  output logic wave
);

  logic [31:0] acc_reg;

  // -------------------------------------------------------------------
  // phase accumulator
  // -------------------------------------------------------------------
  // restart clears the phase so the wave always begins in its low half
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      acc_reg <= 32'h0000_0000;
    else if (restart)
      acc_reg <= 32'h0000_0000;
    else if (run)
      acc_reg <= acc_reg + inc;
  end

  assign wave = acc_reg[31];

endmodule

`default_nettype wire

/* File: rtl/mco_pkg.sv */
// constants, types and helpers for the microcontroller clock output unit
// assumes a single 125 MHz system clock that stands in for the crystal domain
//
// How it works
// [RQ1] divide crystal clock, drive third general pin
// [RQ2] three-bit select picks one of eight frequencies
// [RQ3] after reset the pin carries 1 MHz
// [RQ4] low frequency from RC or external crystal
// [RQ5] crystal oscillator off while asleep; the code keeps it running through the sleep-entry tail (ST_TAIL)
// [RQ6] sleep with enable set: low-frequency clock out
// [RQ7] awake uses select; sleep entry switches automatically
// [RQ8] sleep with enable clear: clock stops
// [RQ9] tail of 0/128/256/512 cycles before stopping
// [RQ10] pending interrupt keeps clock running until read
// [RQ11] any reset restores register defaults
// [RQ12] external crystal select replaces RC source
// [RQ13] source changes and stops are glitch free; the RC/external crystal swap and a software reset do not wait for a low pin
`default_nettype none

package mco_pkg;

  // -------------------------------------------------------------------
  // clock and register map
  // -------------------------------------------------------------------
  localparam longint unsigned CLK_HZ = 125_000_000;
  localparam logic [7:0] CTRL_OFFSET = 8'h0A;
  localparam logic [7:0] CTRL_RESET = 8'h06; // [RQ3]

  // control register layout, bit 0 upward: select, low-freq enable, tail
  typedef struct packed {
    logic [1:0] rsvd;
    logic [1:0] tail_sel;
    logic lfc_en;
    logic [2:0] freq_sel;
  } mco_ctrl_s;

  // -------------------------------------------------------------------
  // output frequencies and selector codes
  // -------------------------------------------------------------------
  localparam longint unsigned FREQ_30M_HZ = 30_000_000;
  localparam longint unsigned FREQ_15M_HZ = 15_000_000;
  localparam longint unsigned FREQ_10M_HZ = 10_000_000;
  localparam longint unsigned FREQ_4M_HZ = 4_000_000;
  localparam longint unsigned FREQ_3M_HZ = 3_000_000;
  localparam longint unsigned FREQ_2M_HZ = 2_000_000;
  localparam longint unsigned FREQ_1M_HZ = 1_000_000;
  localparam logic [2:0] FREQ_SEL_LF = 3'h7;
  localparam logic [2:0] FREQ_SEL_1M = 3'h6;

  // -------------------------------------------------------------------
  // tail lengths in output cycles
  // -------------------------------------------------------------------
  localparam logic [9:0] TAIL_NONE = 10'h000;
  localparam logic [9:0] TAIL_128 = 10'h080;
  localparam logic [9:0] TAIL_256 = 10'h100;
  localparam logic [9:0] TAIL_512 = 10'h200;

  typedef enum {ST_RUN, ST_TAIL, ST_STOP, ST_LF} mco_state_e;
  typedef enum logic [1:0] {SRC_OFF, SRC_NCO, SRC_LF} mco_src_e;

  // phase step of a 32-bit accumulator whose top bit toggles at f_hz
  function automatic logic [31:0] mco_step(input longint unsigned f_hz);
    longint unsigned full;
    full = (f_hz << 32) / CLK_HZ;
    return full[31:0];
  endfunction

  // selector code to accumulator step; the low-frequency code has none
  function automatic logic [31:0] mco_freq_inc(input logic [2:0] sel);
    logic [31:0] inc;
    unique case (sel)
      3'h0: inc = mco_step(FREQ_30M_HZ);
      3'h1: inc = mco_step(FREQ_15M_HZ);
      3'h2: inc = mco_step(FREQ_10M_HZ);
      3'h3: inc = mco_step(FREQ_4M_HZ);
      3'h4: inc = mco_step(FREQ_3M_HZ);
      3'h5: inc = mco_step(FREQ_2M_HZ);
      3'h6: inc = mco_step(FREQ_1M_HZ);
      default: inc = 32'h0000_0000;
    endcase
    return inc;
  endfunction

  localparam logic [31:0] INC_RESET = mco_freq_inc(FREQ_SEL_1M);

  // tail code to number of extra output cycles
  function automatic logic [9:0] mco_tail_cycles(input logic [1:0] code);
    logic [9:0] n;
    unique case (code)
      2'h0: n = TAIL_NONE;
      2'h1: n = TAIL_128;
      2'h2: n = TAIL_256;
      default: n = TAIL_512;
    endcase
    return n;
  endfunction

endpackage

`default_nettype wire
